// file: rtl/bcd_port_pkg.sv
// Constants and types shared by the parallel BCD pressure output port
package bcd_port_pkg;
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned STROBE_US    = 10;
	localparam int unsigned REFRESH_MS   = 500;
	localparam int unsigned LOCK_S       = 5;
	localparam int unsigned STROBE_CYC   = STROBE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned REFRESH_CYC  = REFRESH_MS * (CLK_HZ / 1000);
	localparam int unsigned LOCK_CYC     = LOCK_S * CLK_HZ;
	localparam int unsigned TMR_W        = 27;

	// Function codes entered on the keypad
	localparam logic [4:0] FC_FACTORY = 5'h00;
	localparam logic [4:0] FC_GROUP1  = 5'h05;
	localparam logic [4:0] FC_GROUP2  = 5'h06;

	// Pressure word: mantissa X.XX, exponent sign, tens bit, ones digit
	localparam int unsigned PW_W       = 18;
	localparam int unsigned PW_ONES_LO = 14;
	localparam int unsigned PW_TENTH_LO = 10;
	localparam int unsigned PW_HUND_LO = 6;
	localparam int unsigned PW_SIGN    = 5;
	localparam int unsigned PW_ETENS   = 4;
	localparam int unsigned PW_EONES_LO = 0;
	typedef logic [PW_W-1:0] pword_t;

	// Full scale per unit: 1.00e+3 Torr, 1.33e+3 mbar, 1.33e+5 Pa
	localparam pword_t MAX_TORR = 18'h04023;
	localparam pword_t MAX_MBAR = 18'h04ce3;
	localparam pword_t MAX_PA   = 18'h04ce5;
	localparam pword_t WORD_RST = 18'h00000;

	localparam logic [1:0] UNIT_TORR = 2'h0;
	localparam logic [1:0] UNIT_MBAR = 2'h1;

	typedef enum logic [1:0] {SRC_ION, SRC_CONV, SRC_SYSTEM, SRC_DISPLAY} src_e;
	typedef enum logic {PROG_IDLE, PROG_SHOW} prog_e;
	localparam src_e SRC_RST = SRC_ION;
endpackage

// file: rtl/cycle_timer.sv
// Loadable down counter used for refresh period, strobe width and lock
`timescale 1ns/10ps
module cycle_timer #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_n_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] load_val_in,
	output logic              busy_out
);
	typedef struct packed {
		logic [W-1:0] count;
	} tmr_s;

	tmr_s st_ff;
	tmr_s nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		if (load_in)
			nxt_st.count = load_val_in;
		else if (st_ff.count != '0)
			nxt_st.count = st_ff.count - 1'b1;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign busy_out = (st_ff.count != '0);
endmodule

// file: rtl/bcd_pressure_output_port.sv
// Parallel BCD pressure output port for one display group
`timescale 1ns/10ps
module bcd_pressure_output_port #(
	parameter int unsigned REFRESH_CYC = bcd_port_pkg::REFRESH_CYC,
	parameter int unsigned LOCK_CYC    = bcd_port_pkg::LOCK_CYC
) (
	input  wire logic                       clk_sys_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       float_in,
	input  wire logic                       hold_n_in,
	input  wire logic                       group_sel_in,
	input  wire logic                       unlocked_in,
	input  wire logic                       key_enter_in,
	input  wire logic                       key_select_in,
	input  wire logic [4:0]                 func_code_in,
	input  wire logic [1:0]                 unit_in,
	input  wire logic                       conv_present_in,
	input  wire logic [1:0]                 ion_on_in,
	input  wire logic [1:0]                 disp_ion_in,
	input  wire logic [1:0]                 degas_in,
	input  wire logic                       trouble_in,
	input  wire bcd_port_pkg::pword_t       ion_p_g1_in,
	input  wire bcd_port_pkg::pword_t       ion_p_g2_in,
	input  wire bcd_port_pkg::pword_t       conv_p_g1_in,
	input  wire bcd_port_pkg::pword_t       conv_p_g2_in,
	input  wire bcd_port_pkg::pword_t       disp_p_g1_in,
	input  wire bcd_port_pkg::pword_t       disp_p_g2_in,
	output logic [3:0]                      mant_ones_out,
	output logic [3:0]                      mant_tenths_out,
	output logic [3:0]                      mant_hund_out,
	output logic                            exp_sign_out,
	output logic                            exp_tens_out,
	output logic [3:0]                      exp_ones_out,
	output logic                            gauge_ion_out,
	output logic                            degas_out,
	output logic                            trouble_out,
	output logic                            data_oe_n_out,
	output logic                            refresh_busy_out,
	output logic                            show_ion_led_out,
	output logic                            show_conv_led_out,
	output logic                            security_red_out
);
	typedef struct packed {
		bcd_port_pkg::prog_e  prog;
		bcd_port_pkg::src_e   src;
		bcd_port_pkg::src_e   cand;
		logic                 pend;
		logic                 oe_n;
		bcd_port_pkg::pword_t word;
		logic [2:0]           stat;
	} port_s;

	localparam port_s ST_RST = '{
		prog: bcd_port_pkg::PROG_IDLE,
		src:  bcd_port_pkg::SRC_RST,
		cand: bcd_port_pkg::SRC_RST,
		pend: 1'b0,
		oe_n: 1'b1,
		word: bcd_port_pkg::WORD_RST,
		stat: 3'h0
	};

	port_s st_ff;
	port_s nxt_st;

	logic                 ref_busy;
	logic                 stb_busy;
	logic                 lock_busy;
	logic                 strobe_go;
	logic                 fact_go;
	logic                 may_change;
	logic [4:0]           my_code;
	bcd_port_pkg::pword_t ion_p;
	bcd_port_pkg::pword_t conv_p;
	bcd_port_pkg::pword_t disp_p;
	bcd_port_pkg::pword_t max_p;
	bcd_port_pkg::pword_t conv_or_max;
	bcd_port_pkg::pword_t pick;
	logic                 pick_ion;

	// Group selected by the card jumper
	assign my_code = group_sel_in ? bcd_port_pkg::FC_GROUP2
		: bcd_port_pkg::FC_GROUP1;
	assign ion_p  = group_sel_in ? ion_p_g2_in  : ion_p_g1_in;
	assign conv_p = group_sel_in ? conv_p_g2_in : conv_p_g1_in;
	assign disp_p = group_sel_in ? disp_p_g2_in : disp_p_g1_in;

	always_comb
	begin
		case (unit_in)
			bcd_port_pkg::UNIT_TORR: max_p = bcd_port_pkg::MAX_TORR;
			bcd_port_pkg::UNIT_MBAR: max_p = bcd_port_pkg::MAX_MBAR;
			default:                 max_p = bcd_port_pkg::MAX_PA;
		endcase
	end

	// Missing convection gauge reads as full scale
	assign conv_or_max = conv_present_in ? conv_p : max_p;

	always_comb
	begin
		case (st_ff.src)
			bcd_port_pkg::SRC_ION:
			begin
				pick     = ion_p;
				pick_ion = 1'b1;
			end
			bcd_port_pkg::SRC_CONV:
			begin
				pick     = conv_or_max;
				pick_ion = 1'b0;
			end
			bcd_port_pkg::SRC_SYSTEM:
			begin
				pick     = ion_on_in[group_sel_in] ? ion_p : conv_or_max;
				pick_ion = ion_on_in[group_sel_in];
			end
			default:
			begin
				pick     = disp_p;
				pick_ion = disp_ion_in[group_sel_in];
			end
		endcase
	end

	// Refresh every period unless the reader holds the data
	assign strobe_go = !ref_busy && hold_n_in;

	// A running factory restore also counts as locked
	assign may_change = unlocked_in && !lock_busy;
	assign fact_go = (st_ff.prog == bcd_port_pkg::PROG_IDLE) && key_enter_in
		&& (func_code_in == bcd_port_pkg::FC_FACTORY) && may_change;

	cycle_timer #(.W(bcd_port_pkg::TMR_W)) u_refresh (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.load_in     (!ref_busy),
		.load_val_in (bcd_port_pkg::TMR_W'(REFRESH_CYC - 1)),
		.busy_out    (ref_busy)
	);

	cycle_timer #(.W(bcd_port_pkg::TMR_W)) u_strobe (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.load_in     (strobe_go),
		.load_val_in (bcd_port_pkg::TMR_W'(bcd_port_pkg::STROBE_CYC)),
		.busy_out    (stb_busy)
	);

	cycle_timer #(.W(bcd_port_pkg::TMR_W)) u_lock (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.load_in     (fact_go),
		.load_val_in (bcd_port_pkg::TMR_W'(LOCK_CYC)),
		.busy_out    (lock_busy)
	);

	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.oe_n = float_in;
		nxt_st.pend = strobe_go;
		// Load one cycle after the strobe rises so data moves inside it
		if (st_ff.pend && hold_n_in)
		begin
			nxt_st.word = pick;
			nxt_st.stat = {pick_ion, degas_in[group_sel_in], trouble_in};
		end
		case (st_ff.prog)
			bcd_port_pkg::PROG_IDLE:
			begin
				if (fact_go)
					nxt_st.src = bcd_port_pkg::SRC_RST;
				else if (key_enter_in && func_code_in == my_code)
				begin
					nxt_st.prog = bcd_port_pkg::PROG_SHOW;
					nxt_st.cand = st_ff.src;
				end
			end
			bcd_port_pkg::PROG_SHOW:
			begin
				if (key_enter_in)
				begin
					// Locked confirm just leaves, view only
					if (may_change)
						nxt_st.src = st_ff.cand;
					nxt_st.prog = bcd_port_pkg::PROG_IDLE;
				end
				else if (key_select_in)
					nxt_st.cand = bcd_port_pkg::src_e'(st_ff.cand + 2'h1);
			end
			default:
				nxt_st.prog = bcd_port_pkg::PROG_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	// Digits as 8-4-2-1 positive true nibbles
	assign mant_ones_out   = st_ff.word[bcd_port_pkg::PW_ONES_LO +: 4];
	assign mant_tenths_out = st_ff.word[bcd_port_pkg::PW_TENTH_LO +: 4];
	assign mant_hund_out   = st_ff.word[bcd_port_pkg::PW_HUND_LO +: 4];
	assign exp_sign_out    = st_ff.word[bcd_port_pkg::PW_SIGN];
	assign exp_tens_out    = st_ff.word[bcd_port_pkg::PW_ETENS];
	assign exp_ones_out    = st_ff.word[bcd_port_pkg::PW_EONES_LO +: 4];
	assign gauge_ion_out   = st_ff.stat[2];
	assign degas_out       = st_ff.stat[1];
	assign trouble_out     = st_ff.stat[0];
	assign data_oe_n_out   = st_ff.oe_n;
	assign refresh_busy_out = stb_busy;
	// Lamps: system lights both, display lights neither
	assign show_ion_led_out = (st_ff.prog == bcd_port_pkg::PROG_SHOW)
		&& (st_ff.cand == bcd_port_pkg::SRC_ION
		|| st_ff.cand == bcd_port_pkg::SRC_SYSTEM);
	assign show_conv_led_out = (st_ff.prog == bcd_port_pkg::PROG_SHOW)
		&& (st_ff.cand == bcd_port_pkg::SRC_CONV
		|| st_ff.cand == bcd_port_pkg::SRC_SYSTEM);
	assign security_red_out = !may_change;

	localparam int STB_M1 = 199;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	a_float_release: assert property (float_in |=> data_oe_n_out)
		else $error("float input did not release data lines");
	a_strobe_width: assert property ($rose(refresh_busy_out) |->
		##STB_M1 refresh_busy_out ##1 !refresh_busy_out)
		else $error("refresh strobe width wrong");
	a_hold_freeze: assert property (!hold_n_in |=> $stable(st_ff.word))
		else $error("data changed while held");
	a_change_in_strobe: assert property ($changed(st_ff.word) |->
		refresh_busy_out && $past(refresh_busy_out))
		else $error("data changed outside strobe");
	// Any unit, so the check fires whatever unit the run happens to use
	a_conv_absent_max: assert property (st_ff.pend && hold_n_in
		&& st_ff.src == bcd_port_pkg::SRC_CONV && !conv_present_in
		|=> st_ff.word == ($past(unit_in) == bcd_port_pkg::UNIT_TORR
		? bcd_port_pkg::MAX_TORR : $past(unit_in) == bcd_port_pkg::UNIT_MBAR
		? bcd_port_pkg::MAX_MBAR : bcd_port_pkg::MAX_PA))
		else $error("missing gauge not full scale");
	a_sys_both_leds: assert property (st_ff.prog == bcd_port_pkg::PROG_SHOW
		&& st_ff.cand == bcd_port_pkg::SRC_SYSTEM
		|-> show_ion_led_out && show_conv_led_out)
		else $error("system source lamps wrong");
	a_factory_default: assert property (fact_go |=>
		st_ff.src == bcd_port_pkg::SRC_ION ##1 security_red_out[*8])
		else $error("factory code did not restore ion source");
	a_locked_refuse: assert property (!may_change |=> $stable(st_ff.src))
		else $error("source changed while locked");
	a_code_opens: assert property (st_ff.prog == bcd_port_pkg::PROG_IDLE
		&& key_enter_in && func_code_in == my_code
		|=> st_ff.prog == bcd_port_pkg::PROG_SHOW)
		else $error("own function code ignored");

	c_refresh: cover property ($rose(refresh_busy_out));
	c_commit: cover property (st_ff.prog == bcd_port_pkg::PROG_SHOW
		&& key_enter_in && may_change);
	c_factory: cover property (fact_go);
	c_float: cover property ($rose(data_oe_n_out));
endmodule

// file: testbench/bcd_reader.sv
// Remote reader model that latches the port word while the strobe is low and the lines are driven
`timescale 1ns/10ps
module bcd_reader (
	input  wire logic        clk_sys_in,
	input  wire logic        strobe_in,
	input  wire logic        oe_n_in,
	input  wire logic [17:0] word_in,
	input  wire logic        float_req_in,
	input  wire logic        hold_req_in,
	output logic             float_out,
	output logic             hold_n_out,
	output logic [17:0]      latched_out
);
	// Requests pass straight to the control pins
	assign float_out  = float_req_in;
	assign hold_n_out = !hold_req_in;
	// Lines are ignored during the refresh pulse or when released
	always_ff @(posedge clk_sys_in)
		if (!strobe_in && !oe_n_in)
			latched_out <= word_in;
endmodule

// file: testbench/bcd_pressure_output_port_tb.sv
// Self-checking bench for the parallel BCD pressure output port
`timescale 1ns/10ps
module bcd_pressure_output_port_tb;
	localparam int unsigned RCYC = 400;
	localparam int unsigned LCYC = 50;
	logic       clk_sys_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       float_req = 1'b0, hold_req = 1'b0, float_w, hold_n_w;
	logic       unlocked = 1'b1, key_enter = 1'b0, key_select = 1'b0;
	logic [4:0] code = 5'h00;
	logic [1:0] unit = 2'h0, ion_on = 2'h3, disp_ion = 2'h0, degas = 2'h0;
	logic       conv_present = 1'b1, trouble = 1'b0, group_sel = 1'b0;
	logic [3:0] mo, mt, mh, eo;
	logic       es, et, g_ion, dg, tr, oe_n, busy, led_i, led_c, red;
	logic       prev_low = 1'b0;
	logic [17:0] latched, prev_word, saved;
	bcd_port_pkg::pword_t w [6];
	wire bcd_port_pkg::pword_t word = {mo, mt, mh, es, et, eo};
	int err_count = 0, comparisons = 0, exp_src = 0, n;
	int order [4] = '{1, 2, 0, 3};

	always #25 clk_sys_in = !clk_sys_in;

	bcd_pressure_output_port #(.REFRESH_CYC(RCYC), .LOCK_CYC(LCYC))
		i_bcd_pressure_output_port (.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in), .float_in(float_w), .hold_n_in(hold_n_w),
		.group_sel_in(group_sel), .unlocked_in(unlocked),
		.key_enter_in(key_enter), .key_select_in(key_select),
		.func_code_in(code), .unit_in(unit),
		.conv_present_in(conv_present), .ion_on_in(ion_on),
		.disp_ion_in(disp_ion), .degas_in(degas), .trouble_in(trouble),
		.ion_p_g1_in(w[0]), .ion_p_g2_in(w[1]), .conv_p_g1_in(w[2]),
		.conv_p_g2_in(w[3]), .disp_p_g1_in(w[4]), .disp_p_g2_in(w[5]),
		.mant_ones_out(mo), .mant_tenths_out(mt), .mant_hund_out(mh),
		.exp_sign_out(es), .exp_tens_out(et), .exp_ones_out(eo),
		.gauge_ion_out(g_ion), .degas_out(dg), .trouble_out(tr),
		.data_oe_n_out(oe_n), .refresh_busy_out(busy),
		.show_ion_led_out(led_i), .show_conv_led_out(led_c),
		.security_red_out(red));

	bcd_reader i_bcd_reader (.clk_sys_in(clk_sys_in), .strobe_in(busy),
		.oe_n_in(oe_n), .word_in(word), .float_req_in(float_req),
		.hold_req_in(hold_req), .float_out(float_w),
		.hold_n_out(hold_n_w), .latched_out(latched));

	task finish_test();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task check(input logic [17:0] got, input logic [17:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	// Bench view of the word that the selected source should give
	function logic [17:0] exp_word();
		case (exp_src)
			0: return w[group_sel];
			1: return conv_present ? w[2 + group_sel] : unit == 2'h0 ?
				bcd_port_pkg::MAX_TORR : unit == 2'h1 ?
				bcd_port_pkg::MAX_MBAR : bcd_port_pkg::MAX_PA;
			2: return ion_on[group_sel] ? w[group_sel] : w[2 + group_sel];
			default: return w[4 + group_sel];
		endcase
	endfunction

	// Gauge status line: high when the word comes from the ion gauge
	function logic exp_gauge();
		case (exp_src)
			0: return 1'b1;
			1: return 1'b0;
			2: return ion_on[group_sel];
			default: return disp_ion[group_sel];
		endcase
	endfunction

	function logic [1:0] lamp(input int s);
		return s == 0 ? 2'b10 : s == 1 ? 2'b01 : s == 2 ? 2'b11 : 2'b00;
	endfunction

	// Digits stay legal BCD; ones digit nonzero like a real reading
	function logic [17:0] rnd_word();
		return {4'(1 + $urandom % 9), 4'($urandom % 10), 4'($urandom % 10),
			1'($urandom % 2), 1'($urandom % 2), 4'($urandom % 10)};
	endfunction

	task shuffle();
		foreach (w[i])
			w[i] = rnd_word();
		trouble = 1'($urandom % 2);
		degas = 2'($urandom % 4);
		ion_on = 2'($urandom % 4);
		disp_ion = 2'($urandom % 4);
		unit = 2'($urandom % 4);
	endtask

	task key(input logic sel, input logic [4:0] c);
		code = c;
		key_enter = !sel;
		key_select = sel;
		@(negedge clk_sys_in);
		key_enter = 1'b0;
		key_select = 1'b0;
		@(negedge clk_sys_in);
	endtask

	task wait_refresh();
		n = 0;
		while (busy !== 1'b0 && n < 1000)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		while (busy !== 1'b1 && n < 1000)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		if (n >= 1000)
		begin
			err_count++;
			finish_test();
		end
		n = 0;
		while (busy === 1'b1 && n < 1000)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		check(18'(n), 18'd200);
		@(negedge clk_sys_in);
		check(latched, exp_word());
		check({g_ion, tr, dg}, {exp_gauge(), trouble, degas[group_sel]});
	endtask

	// Data seen while the strobe is low must never move
	always @(negedge clk_sys_in)
	begin
		if (rst_n_in && !busy && prev_low && word !== prev_word)
			check(word, prev_word);
		prev_low = !busy;
		prev_word = word;
	end

	initial
	begin
		n = $urandom(88058);
		shuffle();
		repeat (12) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		wait_refresh();
		foreach (order[k])
		begin
			key(1'b0, bcd_port_pkg::FC_GROUP1);
			check({led_i, led_c}, lamp(exp_src));
			repeat ((order[k] - exp_src + 4) % 4) key(1'b1, 5'h00);
			check({led_i, led_c}, lamp(order[k]));
			key(1'b0, bcd_port_pkg::FC_GROUP1);
			exp_src = order[k];
			shuffle();
			conv_present = (exp_src != 1);
			wait_refresh();
		end
		key(1'b0, bcd_port_pkg::FC_GROUP1);
		key(1'b1, 5'h00);
		unlocked = 1'b0;
		@(negedge clk_sys_in);
		check(red, 1'b1);
		key(1'b0, bcd_port_pkg::FC_GROUP1);
		unlocked = 1'b1;
		wait_refresh();
		key(1'b0, bcd_port_pkg::FC_FACTORY);
		n = 0;
		while (red === 1'b1 && n < 1000)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		check(n >= LCYC - 3 && n <= LCYC + 1, 1'b1);
		exp_src = 0;
		wait_refresh();
		key(1'b0, bcd_port_pkg::FC_GROUP2);
		check({led_i, led_c}, 2'b00);
		hold_req = 1'b1;
		@(negedge clk_sys_in);
		saved = word;
		shuffle();
		repeat (RCYC + 300) @(negedge clk_sys_in);
		check(word, saved);
		hold_req = 1'b0;
		wait_refresh();
		float_req = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		check(oe_n, 1'b1);
		float_req = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		check(oe_n, 1'b0);
		// Jumper moved to the second group: code 6 now owns the port
		group_sel = 1'b1;
		key(1'b0, bcd_port_pkg::FC_GROUP1);
		check({led_i, led_c}, 2'b00);
		key(1'b0, bcd_port_pkg::FC_GROUP2);
		check({led_i, led_c}, lamp(exp_src));
		key(1'b0, bcd_port_pkg::FC_GROUP2);
		shuffle();
		wait_refresh();
		finish_test();
	end
endmodule
